// ==== tb/rmi_board.sv ====
// Board model: reset circuit and interrupt sources driving the device pins
module rmi_board (
	input  wire logic       clk,
	input  wire logic       hold_rst,
	input  wire logic [3:0] act,
	input  wire logic       nmi,
	output logic            reset_pin_n,
	output logic [3:0]      pins_n,
	output logic            nmi_n
);
	timeunit 1ns;
	timeprecision 100ps;
	// Pins move only on the clock edge, so release and requests are clock aligned
	always_ff @(posedge clk) begin
		reset_pin_n <= !hold_rst;
		pins_n      <= ~act;
		nmi_n       <= !nmi;
	end
endmodule // rmi_board

// ==== tb/tb.sv ====
// Self-checking bench for reset release, mode capture and external requests
module tb;
	timeunit 1ns;
	timeprecision 100ps;
	typedef struct packed {
		rmi_pkg::rmi_pwr_e p;
		logic [3:0]        irq;
		logic [3:0]        mask;
		logic [3:0]        exp;
		logic              w;
		logic              s;
	} rmi_row_s;
	logic clk, srst, hold, nmi, rst_n, nmi_n, chip_reset, phase_gen_reset, mode_valid;
	logic [3:0]         act, pins_n, mask, sense, ack, op_mode;
	rmi_pkg::rmi_pwr_e  pwr;
	rmi_pkg::rmi_req_s  req;
	rmi_pkg::rmi_wake_s wake;
	int                 fail_count = 0;
	int                 comparisons = 0;
	int                 n;
	// Rows: power state, asserted pins, mask, expected requests, wait and stop exit
	rmi_row_s rows [6] = '{
		'{rmi_pkg::RMI_RUN, 4'hF, 4'hF, 4'hF, 1'h0, 1'h0},
		'{rmi_pkg::RMI_RUN, 4'hA, 4'h6, 4'h2, 1'h0, 1'h0},
		'{rmi_pkg::RMI_WAIT, 4'h4, 4'h0, 4'h0, 1'h1, 1'h0},
		'{rmi_pkg::RMI_STOP, 4'h4, 4'hF, 4'h4, 1'h0, 1'h0},
		'{rmi_pkg::RMI_STOP, 4'h1, 4'h0, 4'h0, 1'h0, 1'h1},
		'{rmi_pkg::RMI_WAIT, 4'h0, 4'hF, 4'h0, 1'h0, 1'h0}};

	rmi_board rmi_board_inst (.clk(clk), .hold_rst(hold), .act(act), .nmi(nmi),
		.reset_pin_n(rst_n), .pins_n(pins_n), .nmi_n(nmi_n));
	rmi_top rmi_top_inst (.clk(clk), .srst(srst), .reset_pin_n(rst_n),
		.mode_irq_pin_n(pins_n), .pll_init_nonmaskable_irq_n(nmi_n), .irq_mask(mask),
		.irq_edge_sense(sense), .irq_ack(ack), .pwr_state(pwr), .chip_reset(chip_reset),
		.phase_gen_reset(phase_gen_reset), .operating_mode_register(op_mode),
		.mode_valid(mode_valid), .req(req), .wake(wake));

	// 40 MHz clock
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
		comparisons++;
		if (seen !== exp) begin
			fail_count++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic conclude();
		$display("comparisons %0d fail_count %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// Full reset cycle with mode pins held until well after capture
	task automatic do_reset(input logic [3:0] m);
		@(posedge clk);
		hold <= 1'b1;
		act <= m;
		repeat (5) @(posedge clk);
		#1 chk("chip_reset", 8'(chip_reset), 8'h01);
		chk("phase_gen_reset", 8'(phase_gen_reset), 8'h01);
		chk("valid_in_reset", 8'(mode_valid), 8'h00);
		chk("req_in_reset", 8'(req.irq), 8'h00);
		@(posedge clk);
		hold <= 1'b0;
		n = 0;
		while (chip_reset !== 1'b0 && n < 20) begin
			@(posedge clk);
			#1 n++;
		end
		chk("release_latency", 8'(n), 8'h04);
		if (n >= 20) conclude();
		chk("mode", 8'(op_mode), 8'(m));
		chk("mode_valid", 8'(mode_valid), 8'h01);
		@(posedge clk);
		act <= 4'h0;
	endtask

	initial begin
		srst = 1'b1;
		hold = 1'b1;
		nmi = 1'b0;
		act = 4'h0;
		mask = 4'hF;
		sense = 4'h0;
		ack = 4'h0;
		pwr = rmi_pkg::RMI_RUN;
		repeat (6) @(posedge clk);
		srst <= 1'b0;
		do_reset(4'hA);
		// Level requests and wake-up, one row at a time
		foreach (rows[i]) begin
			@(posedge clk);
			pwr <= rows[i].p;
			act <= rows[i].irq;
			mask <= rows[i].mask;
			repeat (5) @(posedge clk);
			#1 chk("req_irq", 8'(req.irq), 8'(rows[i].exp));
			chk("wait_exit", 8'(wake.wait_exit), 8'(rows[i].w));
			chk("stop_exit", 8'(wake.stop_exit), 8'(rows[i].s));
		end
		@(posedge clk);
		pwr <= rmi_pkg::RMI_RUN;
		mask <= 4'hF;
		// Every initial mode, each a reset in mid-run
		for (int m = 0; m < 16; m++) begin
			do_reset(4'(m));
		end
		// Edge request must outlive the pin pulse until acknowledged
		// Let the mode pins settle high first so the edge is a clean one
		repeat (4) @(posedge clk);
		sense <= 4'h2;
		act <= 4'h2;
		repeat (5) @(posedge clk);
		act <= 4'h0;
		repeat (5) @(posedge clk);
		#1 chk("edge_latched", 8'(req.irq), 8'h02);
		@(posedge clk);
		ack <= 4'h2;
		@(posedge clk);
		ack <= 4'h0;
		#1 chk("edge_acked", 8'(req.irq), 8'h00);
		// One pulse per falling edge, however long the pin stays low
		@(posedge clk);
		nmi <= 1'b1;
		n = 0;
		repeat (10) begin
			@(posedge clk);
			#1 if (req.nmi === 1'b1) n++;
		end
		chk("nmi_pulses", 8'(n), 8'h01);
		conclude();
	end
endmodule // tb

// ==== verilog/rmi_pkg.sv ====
// Package for the reset, mode latch and external interrupt input block
package rmi_pkg;

	localparam int          NUM_IRQ        = 4;
	localparam int          SYNC_STAGES    = 2;
	localparam logic [3:0]  MODE_RST_VAL   = 4'h0;
	localparam logic [3:0]  SENSE_LEVEL    = 4'h0;
	localparam int          MODE_BIT_0     = 0;
	localparam int          MODE_BIT_3     = 3;

	// Core power states seen by the wake logic
	typedef enum logic [1:0] {
		RMI_RUN,
		RMI_WAIT,
		RMI_STOP
	} rmi_pwr_e;

	// Interrupt request bundle towards the priority logic
	typedef struct packed {
		logic [3:0] irq;
		logic       nmi;
	} rmi_req_s;

	// Wake-up events towards the power control
	typedef struct packed {
		logic wait_exit;
		logic stop_exit;
	} rmi_wake_s;

endpackage : rmi_pkg

// ==== verilog/rmi_sync.sv ====
// Two flip-flop synchroniser for one asynchronous pin, resets to a given level
module rmi_sync #(
	parameter logic RST_VAL = 1'b1
) (
	input  wire logic clk,
	input  wire logic srst,
	input  wire logic pin,
	output logic      sync
);

	logic meta_ff;
	logic sync_ff;
	logic nxt_meta;
	logic nxt_sync;

	// First stage takes the raw pin with no gate in front; reset acts on stage two only
	always_comb begin
		nxt_meta = pin;
		nxt_sync = meta_ff;
		if (srst) begin
			nxt_sync = RST_VAL;
		end
	end

	always_ff @(posedge clk) begin
		meta_ff <= nxt_meta;
		sync_ff <= nxt_sync;
	end

	assign sync = sync_ff;

endmodule // rmi_sync

// ==== verilog/rmi_top.sv ====
// Reset release, operating mode latch and external interrupt input logic
// Behaviour
// [R1] Reset pin is active low; hysteresis is in the pad, logic sees clean level.
// [R2] Reset release is synchronised to the output clock before leaving reset.
// [R3] While reset is low, chip reset and phase generator reset are held.
// [R4] Reset released synchronously to clock gives fixed start-up latency.
// [R5] At release the four mode pins are stored as the operating mode.
// [R6] During reset the four pins serve only as mode select.
// [R7] The four pins are active low and synchronised to the clock.
// [R8] After reset each pin is a maskable level or falling-edge request.
// [R9] Any asserted request ends the Wait state.
// [R10] Requests asserted synchronously wake several waiting cores together.
// [R11] Only the first request input ends the Stop state.
// [R12] After reset the shared pin is a falling-edge non-maskable request.
// [R13] Mode sampled on the release edge; detection enabled only after capture.
module rmi_top (
	input  wire logic                  clk,
	input  wire logic                  srst,
	input  wire logic                  reset_pin_n,
	input  wire logic [3:0]            mode_irq_pin_n,
	input  wire logic                  pll_init_nonmaskable_irq_n,
	input  wire logic [3:0]            irq_mask,
	input  wire logic [3:0]            irq_edge_sense,
	input  wire logic [3:0]            irq_ack,
	input  wire rmi_pkg::rmi_pwr_e     pwr_state,
	output logic                       chip_reset,
	output logic                       phase_gen_reset,
	output logic [3:0]                 operating_mode_register,
	output logic                       mode_valid,
	output rmi_pkg::rmi_req_s          req,
	output rmi_pkg::rmi_wake_s         wake
);

	logic       rst_sync_n;
	logic [3:0] pin_sync_n;
	logic       nmi_sync_n;

	// Pin synchronisers; hysteresis lives in the pad cell
	rmi_sync #(.RST_VAL(1'b0)) u_rst_sync (  // [R1] [R2]
		.clk  (clk),
		.srst (srst),
		.pin  (reset_pin_n),
		.sync (rst_sync_n)
	);

	rmi_sync #(.RST_VAL(1'b1)) u_nmi_sync (  // [R12]
		.clk  (clk),
		.srst (srst),
		.pin  (pll_init_nonmaskable_irq_n),
		.sync (nmi_sync_n)
	);

	for (genvar i = 0; i < rmi_pkg::NUM_IRQ; i++) begin : g_pin
		rmi_sync #(.RST_VAL(1'b1)) u_sync (  // [R7]
			.clk  (clk),
			.srst (srst),
			.pin  (mode_irq_pin_n[i]),
			.sync (pin_sync_n[i])
		);
	end

	logic       in_reset_ff;
	logic       nxt_in_reset;
	logic [3:0] mode_ff;
	logic [3:0] nxt_mode;
	logic       armed_ff;
	logic       nxt_armed;
	logic [3:0] prev_n_ff;
	logic [3:0] nxt_prev_n;
	logic [3:0] pend_ff;
	logic [3:0] nxt_pend;
	logic       nmi_prev_n_ff;
	logic       nxt_nmi_prev_n;
	logic       nmi_ff;
	logic       nxt_nmi;
	logic [3:0] fall;
	logic [3:0] asserted;

	// Reset tracking, mode capture and arming together on the release edge
	always_comb begin
		nxt_in_reset = ~rst_sync_n;                        // [R3]
		nxt_mode     = mode_ff;
		nxt_armed    = armed_ff;
		if (in_reset_ff && rst_sync_n) begin
			nxt_mode  = ~pin_sync_n;                         // [R5] [R13]
			nxt_armed = 1'b1;                                // [R13]
		end
		if (!rst_sync_n) begin
			nxt_armed = 1'b0;                                // [R6]
		end
		if (srst) begin
			nxt_in_reset = 1'b1;
			nxt_mode     = rmi_pkg::MODE_RST_VAL;
			nxt_armed    = 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		in_reset_ff <= nxt_in_reset;
		mode_ff     <= nxt_mode;
		armed_ff    <= nxt_armed;
	end

	assign asserted = ~pin_sync_n;
	assign fall     = prev_n_ff & ~pin_sync_n;

	// Edge latches; a new edge wins over an acknowledge in the same cycle
	always_comb begin
		nxt_prev_n     = pin_sync_n;
		nxt_pend       = pend_ff & ~irq_ack;
		nxt_nmi_prev_n = nmi_sync_n;
		nxt_nmi        = 1'b0;
		if (armed_ff) begin
			nxt_pend = nxt_pend | (fall & irq_edge_sense);  // [R8]
			nxt_nmi  = nmi_prev_n_ff & ~nmi_sync_n;          // [R12]
		end else begin
			nxt_pend = 4'h0;                                 // [R6]
		end
		if (srst) begin
			nxt_prev_n     = 4'hF;
			nxt_pend       = 4'h0;
			nxt_nmi_prev_n = 1'b1;
			nxt_nmi        = 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		prev_n_ff     <= nxt_prev_n;
		pend_ff       <= nxt_pend;
		nmi_prev_n_ff <= nxt_nmi_prev_n;
		nmi_ff        <= nxt_nmi;
	end

	// Raw request per pin: level or latched edge, before the mask
	logic [3:0] raw_req;
	assign raw_req = armed_ff ? ((asserted & ~irq_edge_sense) | pend_ff) : 4'h0;  // [R8]

	assign chip_reset              = in_reset_ff;       // [R3]
	assign phase_gen_reset         = in_reset_ff;       // [R3]
	assign operating_mode_register = mode_ff;
	assign mode_valid              = armed_ff;
	assign req.irq                 = raw_req & irq_mask; // [R8]
	assign req.nmi                 = nmi_ff;
	// Wake ignores mask so a masked pin still leaves Wait; synchronous edges
	// give every core the same latency: two cycles for level pins, three for edge pins
	assign wake.wait_exit = (pwr_state == rmi_pkg::RMI_WAIT) && (|raw_req);  // [R9] [R10]
	assign wake.stop_exit = (pwr_state == rmi_pkg::RMI_STOP) && raw_req[0];  // [R11]

	// Release only after the high pin has passed both sync stages
	property p_rel;
		@(posedge clk) disable iff (srst)
		$fell(chip_reset) |-> $past(reset_pin_n, 3);
	endproperty
	a_rel: assert property (p_rel) else $error("bad release");  // [R2]

	property p_hold;
		@(posedge clk) disable iff (srst)
		(!reset_pin_n)[*4] |-> chip_reset && phase_gen_reset;
	endproperty
	a_hold: assert property (p_hold) else $error("reset not held");  // [R3]

	property p_lat;
		@(posedge clk) disable iff (srst)
		$rose(reset_pin_n) && chip_reset |-> ##3 !chip_reset;
	endproperty
	a_lat: assert property (p_lat) else $error("start-up latency wrong");  // [R4]

	property p_mode;
		@(posedge clk) disable iff (srst)
		$fell(chip_reset) |-> operating_mode_register == ~$past(pin_sync_n);
	endproperty
	a_mode: assert property (p_mode) else $error("mode not captured");  // [R5]

	property p_noirq;
		@(posedge clk) disable iff (srst)
		chip_reset |-> req.irq == 4'h0 && !req.nmi;
	endproperty
	a_noirq: assert property (p_noirq) else $error("request during reset");  // [R6]

	property p_sync;
		@(posedge clk) disable iff (srst)
		!chip_reset && $fell(mode_irq_pin_n[0]) ##1 !mode_irq_pin_n[0] |-> ##1 asserted[0];
	endproperty
	a_sync: assert property (p_sync) else $error("pin sync latency");  // [R7]

	property p_lvl;
		@(posedge clk) disable iff (srst)
		mode_valid && !irq_edge_sense[1] && irq_mask[1] && !$past(mode_irq_pin_n[1], 2)
			|-> req.irq[1];
	endproperty
	a_lvl: assert property (p_lvl) else $error("level request missing");  // [R8]

	property p_wait;
		@(posedge clk) disable iff (srst)
		pwr_state == rmi_pkg::RMI_WAIT && mode_valid && irq_edge_sense == 4'h0
			&& $past(mode_irq_pin_n, 2) != 4'hF |-> wake.wait_exit;
	endproperty
	a_wait: assert property (p_wait) else $error("wait not exited");  // [R9]

	property p_stop;
		@(posedge clk) disable iff (srst)
		pwr_state == rmi_pkg::RMI_STOP && mode_valid && !irq_edge_sense[0] && !pend_ff[0]
			|-> wake.stop_exit == !$past(mode_irq_pin_n[0], 2);
	endproperty
	a_stop: assert property (p_stop) else $error("stop exit wrong");  // [R11]

	property p_nmi;
		@(posedge clk) disable iff (srst)
		mode_valid && $fell(nmi_sync_n) |=> req.nmi;
	endproperty
	a_nmi: assert property (p_nmi) else $error("nmi edge lost");  // [R12]

	property p_arm;
		@(posedge clk) disable iff (srst)
		$rose(mode_valid) |-> $fell(chip_reset);
	endproperty
	a_arm: assert property (p_arm) else $error("armed before capture");  // [R13]

endmodule // rmi_top
